// File: wio_consts.svh
// Constants for the wireless I/O holding register bank.
// Assumes inclusion by bare name from the design modules.
`ifndef WIO_CONSTS_SVH
`define WIO_CONSTS_SVH

`define WIO_FC_READ 8'h03
`define WIO_FC_WR1 8'h06
`define WIO_FC_WRN 8'h10
`define WIO_EX_NONE 8'h00
`define WIO_EX_FUNC 8'h01
`define WIO_EX_ADDR 8'h02
`define WIO_EX_VALUE 8'h03
`define WIO_RD_MAX 16'h007d
`define WIO_WR_MAX 16'h0078
`define WIO_ADDR_SPAN 17'h10000
`define WIO_NAT_END 16'h0100
`define WIO_ALT_OUT_BASE 16'h0080
`define WIO_ALT_SPARE_BASE 16'h0100
`define WIO_ALT_SPARE_END 16'h0164
`define WIO_REG_COUNT 256
`define WIO_SPARE_COUNT 100
`define WIO_RESET_VALUE 16'h0000

`endif

// File: wio_pkg.sv
// Types shared by the wireless I/O holding register bank.
// Assumes the front end has already framed and checked each request.
`default_nettype none

package wio_pkg;

   typedef enum logic [2:0] {
      WIO_IDLE,
      WIO_SCAN,
      WIO_READ,
      WIO_WRITE,
      WIO_RESP
   } wio_state_t;

   typedef struct packed {
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] qty;
      logic [15:0] data;
   } wio_req_t;

   typedef struct packed {
      logic [7:0] func;
      logic [7:0] exc;
   } wio_resp_t;

   typedef struct packed {
      logic [3:0] dev;
      logic [3:0] point;
      logic [15:0] value;
   } wio_point_t;

endpackage

`default_nettype wire

// File: wio_addr_map.sv
// Address decoder from a protocol register address to a storage slot.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "wio_consts.svh"

module wio_addr_map (
   input wire logic [15:0] addr,
   input wire logic altMap,
   input wire logic [3:0] lastDev,
   output logic hit,
   output logic spare,
   output logic [7:0] idx,
   output logic [6:0] spareIdx
);

   always_comb begin
      hit = 1'b0;
      spare = 1'b0;
      idx = addr[7:0];
      spareIdx = addr[6:0];
      if (!altMap) begin
         // Device blocks of sixteen follow each other from the gateway up.
         hit = (addr < `WIO_NAT_END) && (addr[7:4] <= lastDev);
      end else if (addr < `WIO_ALT_OUT_BASE) begin
         // Input halves of every device come first, then output halves.
         idx = {addr[6:3], 1'b0, addr[2:0]};
         hit = addr[6:3] <= lastDev;
      end else if (addr < `WIO_ALT_SPARE_BASE) begin
         idx = {addr[6:3], 1'b1, addr[2:0]};
         hit = addr[6:3] <= lastDev;
      end else if (addr < `WIO_ALT_SPARE_END) begin
         spare = 1'b1;
         hit = 1'b1;
      end
   end

endmodule

`default_nettype wire

// File: wio_register_bank.sv
// Holding register bank of a wireless I/O gateway, one request at a time.
// Assumes a protocol front end on core_clk delivers decoded requests.
`timescale 1ns/100ps
`default_nettype none
`include "wio_consts.svh"

module wio_register_bank (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic altMap,
   input wire logic [3:0] lastDev,
   input wire logic reqValid,
   input wire wio_pkg::wio_req_t req,
   output logic reqReady,
   input wire logic wrValid,
   input wire logic [15:0] wrData,
   output logic wrReady,
   output logic rdValid,
   output logic [15:0] rdData,
   input wire logic rdReady,
   output logic respValid,
   output wio_pkg::wio_resp_t resp,
   input wire logic ioValid,
   input wire logic [3:0] ioDev,
   input wire logic [3:0] ioPoint,
   input wire logic [15:0] ioValue,
   output logic ptValid,
   output wio_pkg::wio_point_t ptOut
);

   logic [15:0] regMem [0:`WIO_REG_COUNT-1];
   logic [15:0] spareMem [0:`WIO_SPARE_COUNT-1];
   wio_pkg::wio_state_t state;
   wio_pkg::wio_req_t curReq;
   logic [15:0] curAddr;
   logic [15:0] left;
   logic [7:0] excCode;
   logic mapHit;
   logic mapSpare;
   logic [7:0] mapIdx;
   logic [6:0] mapSpareIdx;
   logic wrNow;
   logic [15:0] wrWord;

   function automatic logic [15:0] wioQty(input wio_pkg::wio_req_t r);
      wioQty = (r.func == `WIO_FC_WR1) ? 16'h0001 : r.qty;
   endfunction

   function automatic logic [7:0] wioCheck(input wio_pkg::wio_req_t r);
      logic [16:0] lastAddr;
      lastAddr = {1'b0, r.addr} + {1'b0, r.qty};
      if (!(r.func == `WIO_FC_READ || r.func == `WIO_FC_WR1 ||
            r.func == `WIO_FC_WRN))
         wioCheck = `WIO_EX_FUNC;
      else if (r.func == `WIO_FC_READ &&
               (r.qty == 16'h0000 || r.qty > `WIO_RD_MAX))
         wioCheck = `WIO_EX_VALUE;
      else if (r.func == `WIO_FC_WRN &&
               (r.qty == 16'h0000 || r.qty > `WIO_WR_MAX))
         wioCheck = `WIO_EX_VALUE;
      else if (r.func != `WIO_FC_WR1 && lastAddr > `WIO_ADDR_SPAN)
         wioCheck = `WIO_EX_ADDR;
      else
         wioCheck = `WIO_EX_NONE;
   endfunction

   wio_addr_map u_wio_addr_map (
      .addr(curAddr),
      .altMap(altMap),
      .lastDev(lastDev),
      .hit(mapHit),
      .spare(mapSpare),
      .idx(mapIdx),
      .spareIdx(mapSpareIdx)
   );

   assign wrNow = (state == wio_pkg::WIO_WRITE) &&
                  (curReq.func == `WIO_FC_WR1 || (wrValid && wrReady));
   assign wrWord = (curReq.func == `WIO_FC_WR1) ? curReq.data : wrData;

   // Request sequencing: check, scan every address, then move the data.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= wio_pkg::WIO_IDLE;
         reqReady <= 1'b0;
         wrReady <= 1'b0;
         rdValid <= 1'b0;
         rdData <= 16'h0000;
         respValid <= 1'b0;
         resp <= '0;
         curReq <= '0;
         curAddr <= 16'h0000;
         left <= 16'h0000;
         excCode <= 8'h00;
      end else begin
         respValid <= 1'b0;
         unique case (state)
            wio_pkg::WIO_IDLE: begin
               reqReady <= 1'b1;
               if (reqValid && reqReady) begin
                  // Taking a request closes the door until it is answered.
                  reqReady <= 1'b0;
                  curReq <= req;
                  curAddr <= req.addr;
                  left <= wioQty(req);
                  excCode <= wioCheck(req);
                  if (wioCheck(req) == `WIO_EX_NONE) begin
                     state <= wio_pkg::WIO_SCAN;
                  end else begin
                     state <= wio_pkg::WIO_RESP;
                  end
               end
            end
            wio_pkg::WIO_SCAN: begin
               if (!mapHit) begin
                  excCode <= `WIO_EX_ADDR;
                  state <= wio_pkg::WIO_RESP;
               end else if (left == 16'h0001) begin
                  curAddr <= curReq.addr;
                  left <= wioQty(curReq);
                  if (curReq.func == `WIO_FC_READ) begin
                     state <= wio_pkg::WIO_READ;
                  end else begin
                     state <= wio_pkg::WIO_WRITE;
                     wrReady <= curReq.func == `WIO_FC_WRN;
                  end
               end else begin
                  curAddr <= curAddr + 16'h0001;
                  left <= left - 16'h0001;
               end
            end
            wio_pkg::WIO_READ: begin
               if (!rdValid || rdReady) begin
                  if (left == 16'h0000) begin
                     rdValid <= 1'b0;
                     state <= wio_pkg::WIO_RESP;
                  end else begin
                     rdValid <= 1'b1;
                     // All words are holding registers of the 4xxxx class.
                     rdData <= mapSpare ? spareMem[mapSpareIdx] :
                               regMem[mapIdx];
                     curAddr <= curAddr + 16'h0001;
                     left <= left - 16'h0001;
                  end
               end
            end
            wio_pkg::WIO_WRITE: begin
               if (wrNow) begin
                  curAddr <= curAddr + 16'h0001;
                  left <= left - 16'h0001;
                  if (left == 16'h0001) begin
                     wrReady <= 1'b0;
                     state <= wio_pkg::WIO_RESP;
                  end
               end
            end
            wio_pkg::WIO_RESP: begin
               respValid <= 1'b1;
               resp <= '{func: curReq.func, exc: excCode};
               state <= wio_pkg::WIO_IDLE;
            end
         endcase
      end
   end

   // Point storage: radio updates first, so a host write wins a clash.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `WIO_REG_COUNT; i++) begin
            regMem[i] <= `WIO_RESET_VALUE;
         end
      end else begin
         if (ioValid) begin
            regMem[{ioDev, ioPoint}] <= ioValue;
         end
         if (wrNow && !mapSpare) begin
            regMem[mapIdx] <= wrWord;
         end
      end
   end

   // Spare words only exist in the alternative map.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `WIO_SPARE_COUNT; i++) begin
            spareMem[i] <= `WIO_RESET_VALUE;
         end
      end else if (wrNow && mapSpare) begin
         spareMem[mapSpareIdx] <= wrWord;
      end
   end

   // Each host word stored outside the spares is forwarded to its device point.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ptValid <= 1'b0;
         ptOut <= '0;
      end else begin
         ptValid <= wrNow && !mapSpare;
         ptOut <= '{dev: mapIdx[7:4], point: mapIdx[3:0], value: wrWord};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   one_master_a: assert property (
      reqValid && reqReady |=> !reqReady [*2])
      else $error("Second request taken while busy.");
   bad_func_a: assert property (
      reqValid && reqReady && !(req.func inside {`WIO_FC_READ,
         `WIO_FC_WR1, `WIO_FC_WRN}) |-> ##2 respValid &&
         resp.exc == `WIO_EX_FUNC)
      else $error("Unsupported function not refused.");
   read_qty_a: assert property (
      reqValid && reqReady && req.func == `WIO_FC_READ &&
      req.qty > `WIO_RD_MAX |-> ##2 respValid && resp.exc == `WIO_EX_VALUE)
      else $error("Oversized read not refused.");
   native_map_a: assert property (
      !altMap && curAddr < `WIO_NAT_END && curAddr[7:4] <= lastDev |->
      mapHit && !mapSpare && mapIdx == curAddr[7:0])
      else $error("Native block address misplaced.");
   node_one_a: assert property (
      !altMap && curAddr == 16'h0010 && lastDev != 4'h0 |->
      mapIdx[7:4] == 4'h1 && mapIdx[3:0] == 4'h0)
      else $error("Node one does not start at register 17.");
   beyond_dev_a: assert property (
      state == wio_pkg::WIO_SCAN && !altMap && curAddr[7:4] > lastDev
      |=> state == wio_pkg::WIO_RESP && excCode == `WIO_EX_ADDR)
      else $error("Address past last device not refused.");
   alt_split_a: assert property (
      altMap && curAddr < `WIO_ALT_SPARE_BASE |->
      mapIdx[3] == curAddr[7] && mapIdx[7:4] == curAddr[6:3])
      else $error("Alternative input and output blocks misplaced.");
   alt_spare_a: assert property (
      altMap && curAddr >= `WIO_ALT_SPARE_BASE &&
      curAddr < `WIO_ALT_SPARE_END |-> mapHit && mapSpare)
      else $error("Spare register not decoded.");
   single_write_a: assert property (
      state == wio_pkg::WIO_WRITE && curReq.func == `WIO_FC_WR1 &&
      !mapSpare |=> ptValid && ptOut.value == $past(curReq.data)
      ##1 respValid && resp.exc == `WIO_EX_NONE)
      else $error("Single write not forwarded to its point.");

   read_ok_c: cover property (
      state == wio_pkg::WIO_READ ##[1:20] respValid &&
      resp.exc == `WIO_EX_NONE);
   multi_write_c: cover property (
      wrValid && wrReady ##1 wrValid && wrReady ##[1:10] respValid);
   addr_exc_c: cover property (respValid && resp.exc == `WIO_EX_ADDR);
   spare_write_c: cover property (wrNow && mapSpare);

endmodule

`default_nettype wire

// File: wio_host_model.sv
// Host side model of the holding register bank: takes read words, sends
// write words. Assumes the bank on core_clk; the bench fills wrq.
`timescale 1ns/100ps
`default_nettype none
module wio_host_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic slow,
   input wire logic rdValid,
   input wire logic [15:0] rdData,
   output logic rdReady,
   output logic wrValid,
   output logic [15:0] wrData,
   input wire logic wrReady,
   input wire logic ptValid,
   input wire wio_pkg::wio_point_t ptOut
);
   logic [15:0] wrq[$];
   logic [15:0] rdq[$];
   wio_pkg::wio_point_t ptq[$];
   logic phase;
   // The only master; words go in ascending order and hold until taken.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 1'b0;
         rdReady <= 1'b0;
         wrValid <= 1'b0;
         wrData <= 16'h0000;
      end else begin
         phase <= ~phase;
         rdReady <= !slow || phase;
         if (rdValid && rdReady) begin
            rdq.push_back(rdData);
         end
         if (ptValid) begin
            ptq.push_back(ptOut);
         end
         if (!wrValid || wrReady) begin
            if (wrq.size() > 0 && (!slow || phase)) begin
               wrValid <= 1'b1;
               wrData <= wrq.pop_front();
            end else begin
               wrValid <= 1'b0;
               wrData <= ~wrData;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: test_wio_register_bank.sv
// Self-checking bench of the holding register bank with a host model.
// Assumes the design files and wio_host_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_wio_register_bank;
   logic core_clk, rst_b, altMap, reqValid, reqReady, wrValid, wrReady;
   logic rdValid, rdReady, respValid, ioValid, ptValid, slow;
   logic [3:0] lastDev, ioDev, ioPoint;
   logic [15:0] wrData, rdData, ioValue, ex;
   wio_pkg::wio_req_t req;
   wio_pkg::wio_resp_t resp;
   wio_pkg::wio_point_t ptOut;
   int n_fail, checks;
   wio_register_bank u_wio_register_bank (.core_clk, .rst_b, .altMap,
      .lastDev, .reqValid, .req, .reqReady, .wrValid, .wrData, .wrReady,
      .rdValid, .rdData, .rdReady, .respValid, .resp, .ioValid, .ioDev,
      .ioPoint, .ioValue, .ptValid, .ptOut);
   wio_host_model u_wio_host_model (.core_clk, .rst_b, .slow, .rdValid,
      .rdData, .rdReady, .wrValid, .wrData, .wrReady, .ptValid, .ptOut);
   task automatic end_of_test;
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cmp_word(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_pt(input string nm, input logic [23:0] e, g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [15:0] rq(input int i);
      return u_wio_host_model.rdq[i];
   endfunction
   function automatic logic [23:0] pq(input int i);
      return u_wio_host_model.ptq[i];
   endfunction
   task automatic run(input logic [7:0] f, input logic [15:0] a, q, d);
      int i;
      @(posedge core_clk);
      u_wio_host_model.rdq.delete();
      u_wio_host_model.ptq.delete();
      reqValid <= 1'b1;
      req <= '{f, a, q, d};
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (reqReady !== 1'b1 && i < 300);
      reqValid <= 1'b0;
      if (reqReady !== 1'b1) begin
         n_fail++;
         end_of_test();
      end
      do begin
         @(posedge core_clk);
         i++;
      end while (respValid !== 1'b1 && i < 600);
      if (respValid !== 1'b1) begin
         n_fail++;
         end_of_test();
      end
      ex = {8'h00, resp.exc};
      cmp_word("function", {8'h00, f}, {8'h00, resp.func});
   endtask
   task automatic rdw(input logic [15:0] a, e);
      run(8'h03, a, 16'h0001, 16'h0000);
      cmp_word("read exception", 16'h0000, ex);
      cmp_word("read word", e, rq(0));
   endtask
   task automatic s_reset;
      run(8'h03, 16'h0000, 16'h0010, 16'h0000);
      cmp_word("exception", 16'h0000, ex);
      cmp_word("count", 16'h0010,
         16'(u_wio_host_model.rdq.size()));
      for (int i = 0; i < 16; i++) begin
         cmp_word("reset word", 16'h0000, rq(i));
      end
   endtask
   task automatic s_single;
      run(8'h06, 16'h0010, 16'h0001, 16'hbeef);
      cmp_word("exception", 16'h0000, ex);
      cmp_pt("point", {4'h1, 4'h0, 16'hbeef}, pq(0));
      slow <= 1'b1;
      run(8'h03, 16'h000f, 16'h0002, 16'h0000);
      cmp_word("gateway last", 16'h0000, rq(0));
      cmp_word("node first", 16'hbeef, rq(1));
      slow <= 1'b0;
   endtask
   task automatic s_multi;
      u_wio_host_model.wrq.push_back(16'h1234);
      u_wio_host_model.wrq.push_back(16'h5678);
      run(8'h10, 16'h001e, 16'h0002, 16'h0000);
      cmp_word("exception", 16'h0000, ex);
      cmp_pt("point 15", {4'h1, 4'he, 16'h1234}, pq(0));
      cmp_pt("point 16", {4'h1, 4'hf, 16'h5678}, pq(1));
   endtask
   task automatic s_refuse;
      logic [7:0] f[12] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h0f, 8'h03,
         8'h03, 8'h10, 8'h03, 8'h03, 8'h10, 8'h03};
      logic [15:0] q[12] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001,
         16'h0001, 16'h0000, 16'h007e, 16'h0079, 16'h007d, 16'h0001,
         16'h0002, 16'h0020};
      logic [15:0] a[12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
         16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0020,
         16'h001f, 16'hfff0};
      logic [15:0] e[12] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001,
         16'h0001, 16'h0003, 16'h0003, 16'h0003, 16'h0002, 16'h0002,
         16'h0002, 16'h0002};
      for (int i = 0; i < 12; i++) begin
         run(f[i], a[i], q[i], 16'h0000);
         cmp_word("refusal", e[i], ex);
      end
      rdw(16'h001f, 16'h5678);
   endtask
   task automatic s_radio;
      @(posedge core_clk);
      ioValid <= 1'b1;
      ioDev <= 4'h0;
      ioPoint <= 4'h2;
      ioValue <= 16'ha5a5;
      @(posedge core_clk);
      ioValid <= 1'b0;
      rdw(16'h0002, 16'ha5a5);
   endtask
   task automatic s_alt;
      altMap <= 1'b1;
      run(8'h06, 16'h0089, 16'h0001, 16'h0c0c);
      cmp_pt("output point", {4'h1, 4'h9, 16'h0c0c}, pq(0));
      rdw(16'h0089, 16'h0c0c);
      rdw(16'h0002, 16'ha5a5);
      run(8'h06, 16'h0163, 16'h0001, 16'h7777);
      cmp_word("spare pulses", 16'h0000,
         16'(u_wio_host_model.ptq.size()));
      rdw(16'h0163, 16'h7777);
      run(8'h03, 16'h0164, 16'h0001, 16'h0000);
      cmp_word("past spares", 16'h0002, ex);
      altMap <= 1'b0;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      {rst_b, altMap, reqValid, ioValid, slow} = '0;
      {req, ioDev, ioPoint, ioValue, n_fail, checks} = '0;
      lastDev = 4'h1;
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      s_reset();
      s_single();
      s_multi();
      s_refuse();
      s_radio();
      s_alt();
      end_of_test();
   end
endmodule
`default_nettype wire
